// [logic/drive_reference_register_bank.sv]
// Reference register bank of the drive's serial slave, with the read-only
// monitor words that reflect it, and the outputs the registers steer.
// Assumes the frame layer delivers one word access per strobe, already
// checked for integrity; broadcast inputs come from logic on mclk.
`timescale 1ns/1ps
`default_nettype none
module drive_reference_register_bank
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic reg_ack,
    output logic reg_err,
    input wire logic drive_trip_pin,
    input wire logic [2:0] broadcast_input,
    output logic run_cmd,
    output logic reverse_cmd,
    output logic fault_active,
    output logic injected_external_fault,
    output logic network_reference_select,
    output logic network_run_select,
    output logic [4:0] mfi_cmd,
    output logic [15:0] speed_reference,
    output logic [15:0] loop_setpoint,
    output logic setpoint_from_bus,
    output logic [15:0] analog_out_one,
    output logic [15:0] analog_out_two,
    output logic first_digital_output_terminal,
    output logic second_digital_output_terminal,
    output logic fault_contact_terminal,
    output logic fifth_input_terminal,
    output logic sixth_input_terminal,
    output logic seventh_input_terminal
);
    import drive_ref_pkg::*;

    // Writable reference words
    logic [15:0] command_reg;
    logic [15:0] speed_reg;
    logic [15:0] setpoint_reg;
    logic [15:0] aout_one_reg;
    logic [15:0] aout_two_reg;
    logic [15:0] contact_reg;
    logic [15:0] select_reg;
    // Fault state
    logic trip_level; // Filtered trip pin
    logic [CAUSE_COUNT-1:0] cause_reg;
    logic [CAUSE_COUNT-1:0] set_cause;
    logic fault_reg;
    logic fault_clear;
    // Access decode
    logic wr_cmd;
    logic wr_ok;
    logic access;
    logic [15:0] read_word;

    // Word holds one of the reference registers
    function automatic logic is_reference(input logic [15:0] a);
        return a == ADDR_COMMAND || a == ADDR_SPEED || a == ADDR_SETPOINT ||
            a == ADDR_AOUT_ONE || a == ADDR_AOUT_TWO ||
            a == ADDR_CONTACT || a == ADDR_SELECT;
    endfunction
    // Word falls inside the monitor group
    function automatic logic is_monitor(input logic [15:0] a);
        return a >= ADDR_MON_FIRST && a <= ADDR_MON_LAST;
    endfunction
    // Clamp a signed analog level to the full-scale magnitude
    function automatic logic [15:0] clamp_level(input logic [15:0] v);
        if ($signed(v) > AOUT_FULL_SCALE)
            return AOUT_FULL_SCALE;
        if ($signed(v) < -AOUT_FULL_SCALE)
            return -AOUT_FULL_SCALE;
        return v;
    endfunction

    // Write strobes; read wins nothing, a write takes precedence
    assign access = reg_wr | reg_rd;
    assign wr_ok = reg_wr & is_reference(reg_addr);
    assign wr_cmd = reg_wr & (reg_addr == ADDR_COMMAND);
    assign fault_clear = wr_cmd & reg_wdata[CMD_FAULT_RESET];
    assign set_cause[CAUSE_INJECTED] = wr_cmd & reg_wdata[CMD_EXT_FAULT];
    assign set_cause[CAUSE_TRIP] = trip_level;
    // Trip pin arrives asynchronously
    pin_sync #(
        .WIDTH(1)
    ) u_trip_sync (
        .mclk(mclk),
        .rst_b(rst_b),
        .pin_in(drive_trip_pin),
        .level_out(trip_level)
    );

    // Latched fault; reset strobe clears, a new set survives it
    fault_latch #(
        .CAUSES(CAUSE_COUNT)
    ) u_fault (
        .mclk(mclk),
        .rst_b(rst_b),
        .set_cause(set_cause),
        .clear(fault_clear),
        .cause_reg(cause_reg),
        .active_reg(fault_reg)
    );
    // Command word; unused bits masked off on write
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
            command_reg <= WORD_RESET;
        else if (wr_ok && reg_addr == ADDR_COMMAND)
            command_reg <= reg_wdata & MASK_COMMAND;
    end
    // Full-width numeric words
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            speed_reg <= WORD_RESET;
            setpoint_reg <= WORD_RESET;
            aout_one_reg <= WORD_RESET;
            aout_two_reg <= WORD_RESET;
        end
        else if (wr_ok)
        begin
            // Each word updates only on its own address
            if (reg_addr == ADDR_SPEED)
                speed_reg <= reg_wdata;
            if (reg_addr == ADDR_SETPOINT)
                setpoint_reg <= reg_wdata;
            if (reg_addr == ADDR_AOUT_ONE)
                aout_one_reg <= reg_wdata;
            if (reg_addr == ADDR_AOUT_TWO)
                aout_two_reg <= reg_wdata;
        end
    end

    // Contact override and reference selection words
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            contact_reg <= WORD_RESET;
            select_reg <= WORD_RESET;
        end
        else if (wr_ok)
        begin
            if (reg_addr == ADDR_CONTACT)
                contact_reg <= reg_wdata & MASK_CONTACT;
            if (reg_addr == ADDR_SELECT)
                select_reg <= reg_wdata & MASK_SELECT;
        end
    end

    // Read multiplexer; reserved and unused words read as zero
    always_comb
    begin
        read_word = WORD_RESET;
        unique case (reg_addr)
            ADDR_COMMAND: read_word = command_reg;
            ADDR_SPEED: read_word = speed_reg;
            ADDR_SETPOINT: read_word = setpoint_reg;
            ADDR_AOUT_ONE: read_word = aout_one_reg;
            ADDR_AOUT_TWO: read_word = aout_two_reg;
            ADDR_CONTACT: read_word = contact_reg;
            ADDR_SELECT: read_word = select_reg;
            ADDR_MON_STATUS:
            begin
                read_word[MON_RUN] = run_cmd;
                read_word[MON_REVERSE] = reverse_cmd;
                read_word[MON_READY] = 1'b1;
                read_word[MON_FAULT] = fault_reg;
                read_word[MON_DOUT_ONE] = first_digital_output_terminal;
                read_word[MON_DOUT_TWO] = second_digital_output_terminal;
            end
            ADDR_MON_FAULT:
                read_word[FLT_EXTERNAL] = |cause_reg;
            ADDR_MON_FREQ: read_word = speed_reg;
            default: read_word = WORD_RESET; // Unmapped or unused
        endcase
    end

    // Answer one cycle after each strobe
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            reg_ack <= 1'b0;
            reg_err <= 1'b0;
            reg_rdata <= WORD_RESET;
        end
        else
        begin
            reg_ack <= access;
            // Data stands only with the answer to a plain read
            reg_rdata <= (reg_rd && !reg_wr) ? read_word : WORD_RESET;
            // Refuse writes off reference words and reads of unknown words
            if (reg_wr)
                reg_err <= !is_reference(reg_addr);
            else
                reg_err <= reg_rd && !(is_reference(reg_addr) ||
                    is_monitor(reg_addr) || reg_addr == ADDR_RESERVED);
        end
    end

    // Drive commands; a latched fault forces stop
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            run_cmd <= 1'b0;
            reverse_cmd <= 1'b0;
            fault_active <= 1'b0;
            injected_external_fault <= 1'b0;
            network_reference_select <= 1'b0;
            network_run_select <= 1'b0;
            mfi_cmd <= '0;
        end
        else
        begin
            run_cmd <= command_reg[CMD_RUN] & ~fault_reg;
            reverse_cmd <= command_reg[CMD_REVERSE];
            fault_active <= fault_reg;
            injected_external_fault <= cause_reg[CAUSE_INJECTED];
            network_reference_select <= command_reg[CMD_NET_REF];
            network_run_select <= command_reg[CMD_NET_RUN];
            mfi_cmd <= command_reg[CMD_MFI_HI:CMD_MFI_LO];
        end
    end

    // Numeric outputs; analog levels saturate at full scale
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            speed_reference <= WORD_RESET;
            loop_setpoint <= WORD_RESET;
            setpoint_from_bus <= 1'b0;
            analog_out_one <= WORD_RESET;
            analog_out_two <= WORD_RESET;
        end
        else
        begin
            speed_reference <= speed_reg;
            // Setpoint held at zero while the register is ignored
            setpoint_from_bus <= select_reg[SEL_SETPOINT];
            loop_setpoint <= select_reg[SEL_SETPOINT] ? setpoint_reg
                : WORD_RESET;
            analog_out_one <= clamp_level(aout_one_reg);
            analog_out_two <= clamp_level(aout_two_reg);
        end
    end

    // Contacts and broadcast-gated terminal inputs
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            first_digital_output_terminal <= 1'b0;
            second_digital_output_terminal <= 1'b0;
            fault_contact_terminal <= 1'b0;
            fifth_input_terminal <= 1'b0;
            sixth_input_terminal <= 1'b0;
            seventh_input_terminal <= 1'b0;
        end
        else
        begin
            first_digital_output_terminal <= contact_reg[CON_DOUT_ONE];
            second_digital_output_terminal <= contact_reg[CON_DOUT_TWO];
            // Override bit hands the contact to software
            fault_contact_terminal <= contact_reg[CON_FAULT_OVR]
                ? contact_reg[CON_FAULT_VAL] : fault_reg;
            fifth_input_terminal <= select_reg[SEL_BCAST_LO]
                & broadcast_input[0];
            sixth_input_terminal <= select_reg[SEL_BCAST_LO + 1]
                & broadcast_input[1];
            seventh_input_terminal <= select_reg[SEL_BCAST_LO + 2]
                & broadcast_input[2];
        end
    end

    // Checks on the register bank
    sequence seq_cmd_write;
        reg_wr && reg_addr == ADDR_COMMAND;
    endsequence
    sequence seq_contact_write;
        reg_wr && reg_addr == ADDR_CONTACT;
    endsequence
    chk_run_start: assert property (@(posedge mclk) disable iff (!rst_b)
        seq_cmd_write ##0 (reg_wdata[CMD_RUN] && !reg_wdata[CMD_EXT_FAULT]
        && !fault_reg && !trip_level) ##1 !trip_level |=> run_cmd)
        else $error("run command not raised");
    chk_fault_inject: assert property (@(posedge mclk) disable iff (!rst_b)
        seq_cmd_write ##0 reg_wdata[CMD_EXT_FAULT] |=> fault_reg ##1
        (fault_active && !run_cmd))
        else $error("injected fault not latched");
    chk_fault_reset: assert property (@(posedge mclk) disable iff (!rst_b)
        seq_cmd_write ##0 (reg_wdata[CMD_FAULT_RESET] &&
        !reg_wdata[CMD_EXT_FAULT] && !trip_level) |=> !fault_reg)
        else $error("fault reset ignored");
    chk_mfi_map: assert property (@(posedge mclk) disable iff (!rst_b)
        seq_cmd_write |=> ##1 mfi_cmd == $past(reg_wdata[10:6], 2))
        else $error("input commands misplaced");
    chk_analog_range: assert property (@(posedge mclk) disable iff (!rst_b)
        $signed(analog_out_one) <= AOUT_FULL_SCALE &&
        $signed(analog_out_one) >= -AOUT_FULL_SCALE &&
        $signed(analog_out_two) <= AOUT_FULL_SCALE &&
        $signed(analog_out_two) >= -AOUT_FULL_SCALE)
        else $error("analog level beyond full scale");
    chk_contact_drive: assert property (@(posedge mclk) disable iff (!rst_b)
        seq_contact_write |=> ##1 first_digital_output_terminal ==
        $past(reg_wdata[0], 2) && second_digital_output_terminal ==
        $past(reg_wdata[1], 2))
        else $error("digital output mismatch");
    chk_fault_override: assert property (@(posedge mclk) disable iff (!rst_b)
        seq_contact_write ##0 reg_wdata[CON_FAULT_OVR] |=> ##1
        fault_contact_terminal == $past(reg_wdata[CON_FAULT_VAL], 2))
        else $error("fault contact override failed");
    chk_setpoint_gate: assert property (@(posedge mclk) disable iff (!rst_b)
        !setpoint_from_bus |-> loop_setpoint == WORD_RESET)
        else $error("setpoint used while disabled");
    chk_broadcast_gate: assert property (@(posedge mclk) disable iff (!rst_b)
        !$past(select_reg[SEL_BCAST_LO]) |-> !fifth_input_terminal)
        else $error("broadcast input passed while disabled");
    chk_write_answer: assert property (@(posedge mclk) disable iff (!rst_b)
        reg_wr && is_reference(reg_addr) |=> reg_ack && !reg_err)
        else $error("reference write not accepted");
    chk_monitor_refuse: assert property (@(posedge mclk) disable iff (!rst_b)
        reg_wr && is_monitor(reg_addr) |=> reg_ack && reg_err)
        else $error("monitor write not refused");
    chk_unused_zero: assert property (@(posedge mclk) disable iff (!rst_b)
        reg_rd && !reg_wr && reg_addr == ADDR_COMMAND |=>
        reg_rdata[15:11] == 5'h00 && !reg_rdata[CMD_FAULT_RESET])
        else $error("unused command bits read nonzero");
endmodule // drive_reference_register_bank
`default_nettype wire

// [logic/drive_ref_pkg.sv]
// Constants of the drive reference register bank: offsets, bit positions,
// reset values, write masks and analog output limits.
// Assumes a frame layer that hands over single decoded 16-bit word accesses.
// What this block does
// - Command bit 0 runs, bit 1 reverses
// - Command bit 2 injects an external fault
// - Command bit 3 clears the latched fault
// - Command bits 6..10 are digital inputs 3..7
// - Analog outputs: 726 is 11 V full scale
// - Contact bits 0,1 drive digital outputs
// - Contact bit 6 hands fault contact to bit 7
// - Select bit 1 takes setpoint from register
// - Select bits 12..14 enable broadcast inputs 5..7
// - Reference registers accept reads and writes
// - Monitor registers are read only
package drive_ref_pkg;
    // Reference data word addresses
    localparam logic [15:0] ADDR_RESERVED = 16'h0000;
    localparam logic [15:0] ADDR_COMMAND = 16'h0001;
    localparam logic [15:0] ADDR_SPEED = 16'h0002;
    localparam logic [15:0] ADDR_SETPOINT = 16'h0006;
    localparam logic [15:0] ADDR_AOUT_ONE = 16'h0007;
    localparam logic [15:0] ADDR_AOUT_TWO = 16'h0008;
    localparam logic [15:0] ADDR_CONTACT = 16'h0009;
    localparam logic [15:0] ADDR_SELECT = 16'h000f;
    // Monitor data word addresses
    localparam logic [15:0] ADDR_MON_FIRST = 16'h0020;
    localparam logic [15:0] ADDR_MON_STATUS = 16'h0020;
    localparam logic [15:0] ADDR_MON_FAULT = 16'h0021;
    localparam logic [15:0] ADDR_MON_FREQ = 16'h0023;
    localparam logic [15:0] ADDR_MON_LAST = 16'h002a;
    // Command word bit positions
    localparam int CMD_RUN = 0;
    localparam int CMD_REVERSE = 1;
    localparam int CMD_EXT_FAULT = 2;
    localparam int CMD_FAULT_RESET = 3;
    localparam int CMD_NET_REF = 4;
    localparam int CMD_NET_RUN = 5;
    localparam int CMD_MFI_LO = 6;
    localparam int CMD_MFI_HI = 10;
    // Contact output bit positions
    localparam int CON_DOUT_ONE = 0;
    localparam int CON_DOUT_TWO = 1;
    localparam int CON_FAULT_OVR = 6;
    localparam int CON_FAULT_VAL = 7;
    // Reference selection bit positions
    localparam int SEL_SETPOINT = 1;
    localparam int SEL_BCAST_LO = 12;
    // Monitor status and fault detail bit positions
    localparam int MON_RUN = 0;
    localparam int MON_REVERSE = 1;
    localparam int MON_READY = 2;
    localparam int MON_FAULT = 3;
    localparam int MON_DOUT_ONE = 5;
    localparam int MON_DOUT_TWO = 6;
    localparam int FLT_EXTERNAL = 7;
    // Storage masks; the reset bit is a strobe and never stored
    localparam logic [15:0] MASK_COMMAND = 16'h07f7;
    localparam logic [15:0] MASK_CONTACT = 16'h00c3;
    localparam logic [15:0] MASK_SELECT = 16'h7002;
    // Value of every register after reset
    localparam logic [15:0] WORD_RESET = 16'h0000;
    // Analog output scaling: full scale 11 V, 10 V point
    localparam logic signed [15:0] AOUT_FULL_SCALE = 16'sh02d6;
    localparam logic signed [15:0] AOUT_TEN_VOLT = 16'sh0294;
    // Fault cause indices
    localparam int CAUSE_INJECTED = 0;
    localparam int CAUSE_TRIP = 1;
    localparam int CAUSE_COUNT = 2;
endpackage

// [logic/pin_sync.sv]
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes inputs may change at any time relative to mclk.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level_out
);
    // Refuse an empty bundle
    if (WIDTH < 1)
    begin : g_width_check
        $error("pin_sync needs at least one bit");
    end

    logic [WIDTH-1:0] stage1_reg; // Metastable stage, read by stage2 only
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;

    // Shift chain
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            stage1_reg <= '0;
            stage2_reg <= '0;
            stage3_reg <= '0;
        end
        else
        begin
            stage1_reg <= pin_in;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // Accept a change only once two settled stages agree
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
            level_out <= '0;
        else
        begin
            for (int i = 0; i < WIDTH; i++)
            begin
                if (stage2_reg[i] == stage3_reg[i])
                    level_out[i] <= stage3_reg[i];
            end
        end
    end
endmodule // pin_sync
`default_nettype wire

// [logic/fault_latch.sv]
// Sticky fault latch with per-cause record and a clear strobe.
// Assumes set and clear come from logic on mclk.
`timescale 1ns/1ps
`default_nettype none
module fault_latch #(
    parameter int CAUSES = 2
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [CAUSES-1:0] set_cause,
    input wire logic clear,
    output logic [CAUSES-1:0] cause_reg,
    output logic active_reg
);
    // Refuse an empty cause list
    if (CAUSES < 1)
    begin : g_cause_check
        $error("fault_latch needs at least one cause");
    end

    // Set wins over a clear in the same cycle so no event is lost
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
            cause_reg <= '0;
        else if (clear)
            cause_reg <= set_cause;
        else
            cause_reg <= cause_reg | set_cause;
    end

    // Summary flag kept in step with the record
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
            active_reg <= 1'b0;
        else if (clear)
            active_reg <= |set_cause;
        else
            active_reg <= active_reg | (|set_cause);
    end
endmodule // fault_latch
`default_nettype wire

// [tb/bus_master_model.sv]
// Bus master model: single word reads and writes into the bank.
// Assumes the bank answers one cycle after each strobe, on mclk.
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
    input wire logic mclk,
    output logic [15:0] reg_addr,
    output logic [15:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_ack,
    input wire logic reg_err
);
    // Idle bus at time zero, no strobe
    initial
    begin
        reg_addr = 16'hffff;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // One-cycle strobe; caller keeps unused bits zero and avoids
    // reserved words unless a test means to break that
    task automatic access(input logic wr, input logic [15:0] addr,
        input logic [15:0] data, output logic [15:0] rdata,
        output logic ack, output logic err);
        @(negedge mclk);
        reg_addr = addr;
        reg_wdata = data;
        reg_wr = wr;
        reg_rd = !wr;
        @(negedge mclk);
        // Released lines show the inverse, so stale values never match
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~addr;
        reg_wdata = ~data;
        rdata = reg_rdata;
        ack = reg_ack;
        err = reg_err;
    endtask
endmodule // bus_master_model
`default_nettype wire

// [tb/drive_reference_register_bank_tb.sv]
// Self-checking bench of the reference register bank.
// Assumes the master model in bus_master_model and the design package.
`timescale 1ns/1ps
`default_nettype none
module drive_reference_register_bank_tb;
    import drive_ref_pkg::*;
    typedef struct {logic [15:0] a; logic [15:0] d; logic [15:0] q;} row_type;
    logic mclk, rst_b, drive_trip_pin, reg_wr, reg_rd, reg_ack, reg_err;
    logic [15:0] reg_addr, reg_wdata, reg_rdata, speed_reference;
    logic [15:0] loop_setpoint, analog_out_one, analog_out_two, rdat;
    logic [2:0] broadcast_input;
    logic run_cmd, reverse_cmd, fault_active, injected_external_fault;
    logic network_reference_select, network_run_select, setpoint_from_bus;
    logic first_digital_output_terminal, second_digital_output_terminal;
    logic fault_contact_terminal, fifth_input_terminal, ack, err;
    logic sixth_input_terminal, seventh_input_terminal;
    logic [4:0] mfi_cmd;
    logic [13:0] lv; // Packed single-bit levels
    int fail_count = 0, comparisons = 0, cycles = 0;
    // Write row, read back expected; 0x7/0x8 overrange to hit the clamp
    row_type rows [7] = '{'{16'h0001, 16'h07f3, 16'h07f3},
        '{16'h0002, 16'h1234, 16'h1234}, '{16'h0006, 16'h0abc, 16'h0abc},
        '{16'h0007, 16'h7fff, 16'h7fff}, '{16'h0008, 16'h8000, 16'h8000},
        '{16'h0009, 16'h00c3, 16'h00c3}, '{16'h000f, 16'h7002, 16'h7002}};

    assign lv = {run_cmd, reverse_cmd, mfi_cmd, setpoint_from_bus,
        first_digital_output_terminal, second_digital_output_terminal,
        fault_contact_terminal, fifth_input_terminal, sixth_input_terminal,
        seventh_input_terminal};

    drive_reference_register_bank u_drive_reference_register_bank (.mclk,
        .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_ack,
        .reg_err, .drive_trip_pin, .broadcast_input, .run_cmd, .reverse_cmd,
        .fault_active, .injected_external_fault, .network_reference_select,
        .network_run_select, .mfi_cmd, .speed_reference, .loop_setpoint,
        .setpoint_from_bus, .analog_out_one, .analog_out_two,
        .first_digital_output_terminal, .second_digital_output_terminal,
        .fault_contact_terminal, .fifth_input_terminal, .sixth_input_terminal,
        .seventh_input_terminal);
    bus_master_model u_bus_master_model (.mclk, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .reg_ack, .reg_err);

    // 250 MHz clock
    always #2 mclk = ~mclk;

    // Hang guard, well above the hundred or so cycles the tests need
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fail_count++;
            tally_and_finish();
        end
    end

    // Compare and count; four-state so unknowns never match
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One access through the master; every access must be answered
    task automatic acc(input logic w, input logic [15:0] a,
        input logic [15:0] d);
        u_bus_master_model.access(w, a, d, rdat, ack, err);
        chk(ack, 1'b1);
    endtask

    // Levels trail the register write by two edges
    task automatic settle();
        repeat (2) @(negedge mclk);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        mclk = 1'b0;
        rst_b = 1'b0;
        drive_trip_pin = 1'b0;
        broadcast_input = 3'b111;
        repeat (4) @(negedge mclk);
        rst_b = 1'b1;
        chk(lv, 14'h0000);
        acc(1'b0, ADDR_COMMAND, 16'h0000);
        chk(rdat, WORD_RESET);
        $display("reset test done");
        foreach (rows[i])
        begin
            acc(1'b1, rows[i].a, rows[i].d);
            chk(err, 1'b0);
            acc(1'b0, rows[i].a, 16'h0000);
            chk(rdat, rows[i].q);
        end
        settle();
        chk(lv, 14'h3fff);
        chk(speed_reference, 16'h1234);
        chk({network_reference_select, network_run_select}, 2'b11);
        chk(loop_setpoint, 16'h0abc);
        chk({analog_out_one, analog_out_two}, 32'h02d6fd2a);
        $display("table test done");
        // All ones, unused bits included on purpose
        acc(1'b1, ADDR_COMMAND, 16'hffff);
        acc(1'b0, ADDR_COMMAND, 16'h0000);
        chk(rdat, 16'h07f7);
        settle();
        chk({fault_active, injected_external_fault, run_cmd}, 3'b110);
        chk(fault_contact_terminal, 1'b1);
        acc(1'b1, ADDR_CONTACT, 16'h0040);
        settle();
        chk(fault_contact_terminal, 1'b0);
        acc(1'b1, ADDR_CONTACT, 16'h0000);
        settle();
        chk(lv[5:3], 3'b001);
        acc(1'b1, ADDR_COMMAND, 16'h0009);
        settle();
        chk({fault_active, injected_external_fault, run_cmd}, 3'b001);
        $display("fault test done");
        // Refused writes: reserved word and monitor status word; reads of both are accepted
        acc(1'b1, ADDR_RESERVED, 16'h5555);
        chk(err, 1'b1);
        acc(1'b0, ADDR_RESERVED, 16'h0000);
        chk({err, rdat}, 17'h00000);
        acc(1'b1, ADDR_MON_STATUS, 16'hffff);
        chk(err, 1'b1);
        acc(1'b0, ADDR_MON_STATUS, 16'h0000);
        chk({err, rdat[0]}, 2'b01);
        // Unused word: read refused, data zero
        acc(1'b0, 16'h0003, 16'h0000);
        chk({err, rdat}, 17'h10000);
        $display("refusal test done");
        acc(1'b1, ADDR_SELECT, 16'h0000);
        settle();
        chk({setpoint_from_bus, loop_setpoint}, 17'h00000);
        // Each broadcast enable alone, then enabled with no data
        for (int i = 0; i < 3; i++)
        begin
            acc(1'b1, ADDR_SELECT, 16'h1000 << i);
            settle();
            chk(lv[2:0], 3'b100 >> i);
        end
        broadcast_input = 3'b000;
        acc(1'b1, ADDR_SELECT, 16'h7000);
        settle();
        chk(lv[2:0], 3'b000);
        $display("select test done");
        // Trip pin latches a fault; a reset strobe loses while it stands
        drive_trip_pin = 1'b1;
        repeat (8) @(negedge mclk);
        chk({fault_active, injected_external_fault, run_cmd}, 3'b100);
        acc(1'b1, ADDR_COMMAND, 16'h0009);
        settle();
        chk(fault_active, 1'b1);
        drive_trip_pin = 1'b0;
        repeat (8) @(negedge mclk);
        acc(1'b1, ADDR_COMMAND, 16'h0009);
        settle();
        chk({fault_active, injected_external_fault, run_cmd}, 3'b001);
        $display("trip test done");
        // Reset in mid-run returns the packed levels, fault flag, speed output and speed word to zero
        rst_b = 1'b0;
        repeat (2) @(negedge mclk);
        rst_b = 1'b1;
        chk({lv, fault_active, speed_reference}, 31'h0);
        acc(1'b0, ADDR_SPEED, 16'h0000);
        chk(rdat, WORD_RESET);
        $display("second reset test done");
        tally_and_finish();
    end
endmodule // drive_reference_register_bank_tb
`default_nettype wire
